// [shared/scs_pkg.sv]
// Constants, types and helpers for the storage card security command block.
// Assumes a 32-bit AXI4-Lite register bus and a single 25 MHz clock domain.
package scs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_FEATURE  = 4'h1;
  localparam logic [3:0] IDX_COUNT    = 4'h2;
  localparam logic [3:0] IDX_SECTOR   = 4'h3;
  localparam logic [3:0] IDX_TRK_LO   = 4'h4;
  localparam logic [3:0] IDX_TRK_HI   = 4'h5;
  localparam logic [3:0] IDX_UNITHEAD = 4'h6;
  localparam logic [3:0] IDX_OPCODE   = 4'h7;
  localparam logic [3:0] IDX_DATA     = 4'h8;
  localparam logic [3:0] IDX_STATUS   = 4'h9;
  localparam logic [3:0] IDX_GEOM     = 4'hA;
  localparam logic [3:0] IDX_CAPACITY = 4'hB;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes
  localparam logic [7:0] OP_SET_PW     = 8'hF1;
  localparam logic [7:0] OP_UNLOCK     = 8'hF2;
  localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
  localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
  localparam logic [7:0] OP_FREEZE     = 8'hF5;
  localparam logic [7:0] OP_DISABLE_PW = 8'hF6;
  localparam logic [3:0] OP_SEEK_HI    = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Password sector layout and field positions
  localparam logic [7:0] SECT_LAST_WORD = 8'hFF;
  localparam logic [7:0] PW_LAST_WORD   = 8'h10;
  localparam int unsigned CW_ID_BIT     = 0;
  localparam int unsigned CW_LEVEL_BIT  = 8;
  localparam int unsigned CDH_LBA_BIT   = 6;
  localparam int unsigned ERR_ABRT_BIT  = 2;
  localparam int unsigned ERR_IDNF_BIT  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [2:0]  UNLOCK_TRIES_RST = 3'h5;
  localparam logic [19:0] GEOM_RST         = 20'hF_0400;
  localparam logic [27:0] CAPACITY_RST     = 28'h000_4000;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_DECERR      = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_EXEC} scs_state_t;

  // Status word, bit 0 upward: busy, drq, err, done, frozen, locked, ...
  typedef struct packed {
    logic [2:0] tries;
    logic       level_max;
    logic       armed;
    logic       locked;
    logic       frozen;
    logic       done;
    logic       err;
    logic       drq;
    logic       busy;
  } scs_status_t;

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] scs_merge(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wdat[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Register index from a byte address; 4'h0 when outside the window
  function automatic logic [3:0] scs_index(input logic [7:0] addr);
    return (addr[7:6] == 2'h0) ? addr[5:2] : 4'h0;
  endfunction

endpackage

// [design/scs_core.sv]
// Security command interpreter of a flash storage card, with AXI4-Lite regs.
// Assumes the host obeys AXI4-Lite handshakes; passwords live in storage
// that aresetn never clears, modelling retention across card resets.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps

// Operation
// - Erase-unit takes one full password sector first
// - Erase-unit password mismatch aborts, erases nothing
// - Erase-unit aborts unless erase-prepare came directly before
// - Freeze-lock enters frozen state, blocks lock changes
// - Frozen rejects set, unlock, disable, erase-unit
// - Only reset clears frozen state
// - Freeze-lock while frozen completes, stays frozen
// - Freeze-lock completion zeroes transfer count
// - Without security, freeze opcode runs wear spreading
// - Sector word0: id bit0, level bit8, password words
// - User/high: store user, arm lock, both unlock
// - User/max: store user, arm, user-only unlock
// - Master: store master, lock and level unchanged
// - Master unlock compares at high, rejected at max
// - User unlock compares stored user password
// - Tries start five, locked mismatch aborts, decrements
// - Zero tries aborts unlock and erase-unit
// - Unlock while unlocked leaves tries unchanged
// - Seek only range-checks address, error if out
// - Control bit0 selects user or master compare
// - Erase-prepare opcode recognised, enables next erase-unit
module scs_core
  import scs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        nv_resetn,
  input  wire logic        sec_supported,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             busy,
  output logic             erase_unit_go,
  output logic             wear_spread_cmd
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic         aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0]   awaddr_q;
  logic [31:0]  wdata_q, rdata_q, rd_word_c;
  logic [3:0]   wstrb_q, wr_idx, rd_idx;
  logic [1:0]   bresp_q, rresp_q;
  logic         wr_fire, wr_hit, rd_hit;
  scs_state_t   state_q;
  logic [7:0]   opcode_q, wcnt_q, err_q;
  logic [15:0]  ctrl_q;
  logic [255:0] pwbuf_q, user_pw_q, master_pw_q;
  logic [7:0]   count_q, sector_q, trk_lo_q, trk_hi_q, unithead_q;
  logic [19:0]  geom_q;
  logic [27:0]  capacity_q;
  logic         done_q, frozen_q, locked_q, prep_q, armed_q, level_max_q;
  logic [2:0]   tries_q;
  logic         erase_go_q, wear_go_q;
  logic         exec, op_start, data_wr, pw_match_c, abort_c, idnf_c, addr_ok_c;
  logic         needs_sector_c;
  logic [3:0]   pw_slot;
  scs_status_t  status_c;

  assign exec    = (state_q == ST_EXEC);
  assign busy    = (state_q != ST_IDLE);
  assign pw_slot = 4'(wcnt_q - 8'h01);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire       = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_idx        = scs_index(awaddr_q);
  assign wr_hit        = (wr_idx != 4'h0) && (wr_idx <= IDX_CAPACITY);
  assign op_start      = wr_fire && (wr_idx == IDX_OPCODE) && wstrb_q[0] &&
                         (state_q == ST_IDLE);
  // Password words must arrive as full 16-bit lanes
  assign data_wr       = wr_fire && (wr_idx == IDX_DATA) && (&wstrb_q[1:0]) &&
                         (state_q == ST_XFER);

  // Hold each channel until both have arrived, then answer once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, one cycle to answer
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rd_idx        = scs_index(s_axi_araddr);
  assign rd_hit        = (rd_idx != 4'h0) && (rd_idx <= IDX_CAPACITY);

  // Status snapshot shared by two read addresses
  always_comb begin
    status_c           = '0;
    status_c.busy      = busy;
    status_c.drq       = (state_q == ST_XFER);
    status_c.err       = (err_q != 8'h00);
    status_c.done      = done_q;
    status_c.frozen    = frozen_q;
    status_c.locked    = locked_q;
    status_c.armed     = armed_q;
    status_c.level_max = level_max_q;
    status_c.tries     = tries_q;
  end

  // Read mux; write-only feature slot returns the error byte
  always_comb begin
    rd_word_c = 32'h0000_0000;
    case (rd_idx)
      IDX_FEATURE:  rd_word_c[7:0]  = err_q;
      IDX_COUNT:    rd_word_c[7:0]  = count_q;
      IDX_SECTOR:   rd_word_c[7:0]  = sector_q;
      IDX_TRK_LO:   rd_word_c[7:0]  = trk_lo_q;
      IDX_TRK_HI:   rd_word_c[7:0]  = trk_hi_q;
      IDX_UNITHEAD: rd_word_c[7:0]  = unithead_q;
      IDX_OPCODE:   rd_word_c[7:0]  = status_c[7:0];
      IDX_STATUS:   rd_word_c[10:0] = status_c;
      IDX_GEOM:     rd_word_c[19:0] = geom_q;
      IDX_CAPACITY: rd_word_c[27:0] = capacity_q;
      default:      rd_word_c       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word_c;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Task-file registers; host writes ignored while a command runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q    <= 8'h00;
      sector_q   <= 8'h00;
      trk_lo_q   <= 8'h00;
      trk_hi_q   <= 8'h00;
      unithead_q <= 8'h00;
      geom_q     <= GEOM_RST;
      capacity_q <= CAPACITY_RST;
    end else if (exec && opcode_q == OP_FREEZE && sec_supported) begin
      count_q <= 8'h00;
    end else if (wr_fire && state_q == ST_IDLE) begin
      if (wr_idx == IDX_COUNT && wstrb_q[0])    count_q    <= wdata_q[7:0];
      if (wr_idx == IDX_SECTOR && wstrb_q[0])   sector_q   <= wdata_q[7:0];
      if (wr_idx == IDX_TRK_LO && wstrb_q[0])   trk_lo_q   <= wdata_q[7:0];
      if (wr_idx == IDX_TRK_HI && wstrb_q[0])   trk_hi_q   <= wdata_q[7:0];
      if (wr_idx == IDX_UNITHEAD && wstrb_q[0]) unithead_q <= wdata_q[7:0];
      if (wr_idx == IDX_GEOM) begin
        geom_q <= 20'(scs_merge(32'(geom_q), wdata_q, wstrb_q));
      end
      if (wr_idx == IDX_CAPACITY) begin
        capacity_q <= 28'(scs_merge(32'(capacity_q), wdata_q, wstrb_q));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decision, evaluated in the single execute cycle
  assign needs_sector_c = (wdata_q[7:0] == OP_SET_PW) ||
                          (wdata_q[7:0] == OP_UNLOCK) ||
                          (wdata_q[7:0] == OP_ERASE_UNIT) ||
                          (wdata_q[7:0] == OP_DISABLE_PW);
  assign pw_match_c = ctrl_q[CW_ID_BIT] ? (pwbuf_q == master_pw_q)
                                        : (pwbuf_q == user_pw_q);
  // Track bytes hold LBA 23..8, low head field LBA 27..24
  assign addr_ok_c  = unithead_q[CDH_LBA_BIT] ?
                      ({unithead_q[3:0], trk_hi_q, trk_lo_q, sector_q} < capacity_q) :
                      (({trk_hi_q, trk_lo_q} < geom_q[15:0]) &&
                       (unithead_q[3:0] <= geom_q[19:16]));

  always_comb begin
    abort_c = 1'b0;
    idnf_c  = 1'b0;
    if (opcode_q[7:4] == OP_SEEK_HI) begin
      idnf_c = !addr_ok_c;
    end else begin
      case (opcode_q)
        OP_SET_PW:     abort_c = frozen_q || !sec_supported;
        OP_UNLOCK:     abort_c = frozen_q || !sec_supported ||
                                 (tries_q == 3'h0) ||
                                 (ctrl_q[CW_ID_BIT] && level_max_q) ||
                                 !pw_match_c;
        OP_ERASE_PREP: abort_c = !sec_supported;
        OP_ERASE_UNIT: abort_c = !prep_q || frozen_q ||
                                 (tries_q == 3'h0) ||
                                 !sec_supported || !pw_match_c;
        OP_FREEZE:     abort_c = 1'b0;
        OP_DISABLE_PW: abort_c = frozen_q || !sec_supported || !pw_match_c;
        default:       abort_c = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer: take opcode, gather sector, execute, finish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q  <= ST_IDLE;
      opcode_q <= 8'h00;
      wcnt_q   <= 8'h00;
      ctrl_q   <= 16'h0000;
      pwbuf_q  <= '0;
      err_q    <= 8'h00;
      done_q   <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (op_start) begin
          opcode_q <= wdata_q[7:0];
          wcnt_q   <= 8'h00;
          err_q    <= 8'h00;
          done_q   <= 1'b0;
          state_q  <= needs_sector_c ? ST_XFER : ST_EXEC;
        end
        ST_XFER: if (data_wr) begin
          // Words past the password are drained and dropped
          if (wcnt_q == 8'h00) begin
            ctrl_q <= wdata_q[15:0];
          end else if (wcnt_q <= PW_LAST_WORD) begin
            pwbuf_q[{pw_slot, 4'h0} +: 16] <= wdata_q[15:0];
          end
          wcnt_q <= wcnt_q + 8'h01;
          if (wcnt_q == SECT_LAST_WORD) begin
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          err_q[ERR_ABRT_BIT] <= abort_c;
          err_q[ERR_IDNF_BIT] <= idnf_c;
          done_q              <= 1'b1;
          state_q             <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Volatile lock state; lock taken from the armed flag at each reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frozen_q <= 1'b0;
      tries_q  <= UNLOCK_TRIES_RST;
      prep_q   <= 1'b0;
      locked_q <= armed_q;
    end else if (exec) begin
      // Any other command breaks the prepare-then-erase pairing
      prep_q <= (opcode_q == OP_ERASE_PREP) && sec_supported;
      if (opcode_q == OP_FREEZE && sec_supported) begin
        frozen_q <= 1'b1;
      end
      if ((opcode_q == OP_UNLOCK || opcode_q == OP_ERASE_UNIT ||
           opcode_q == OP_DISABLE_PW) && !abort_c) begin
        locked_q <= 1'b0;
      end
      // Only a rejected unlock on a locked card spends a try
      if (opcode_q == OP_UNLOCK && abort_c && locked_q && !frozen_q &&
          sec_supported && tries_q != 3'h0) begin
        tries_q <= tries_q - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retained passwords and lock arming
  always_ff @(posedge aclk) begin
    if (!nv_resetn) begin
      armed_q     <= 1'b0;
      level_max_q <= 1'b0;
      user_pw_q   <= '0;
      master_pw_q <= '0;
    end else if (exec && !abort_c) begin
      if (opcode_q == OP_SET_PW && ctrl_q[CW_ID_BIT]) begin
        master_pw_q <= pwbuf_q;
      end else if (opcode_q == OP_SET_PW) begin
        user_pw_q   <= pwbuf_q;
        armed_q     <= 1'b1;
        level_max_q <= ctrl_q[CW_LEVEL_BIT];
      end else if (opcode_q == OP_ERASE_UNIT) begin
        user_pw_q <= '0;
        armed_q   <= 1'b0;
      end else if (opcode_q == OP_DISABLE_PW) begin
        armed_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle strobes to the media side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_go_q <= 1'b0;
      wear_go_q  <= 1'b0;
    end else begin
      erase_go_q <= exec && opcode_q == OP_ERASE_UNIT && !abort_c;
      wear_go_q  <= exec && opcode_q == OP_FREEZE && !sec_supported;
    end
  end

  assign erase_unit_go   = erase_go_q;
  assign wear_spread_cmd = wear_go_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sector_first;
    exec && opcode_q == OP_ERASE_UNIT |-> $past(state_q) == ST_XFER && $past(wcnt_q) == 8'hFF;
  endproperty
  a_sector_first: assert property (p_sector_first) else $error("erase ran without a sector");

  property p_mismatch_no_erase;
    exec && opcode_q == OP_ERASE_UNIT && !pw_match_c |=> err_q[2] && !erase_unit_go;
  endproperty
  a_mismatch_no_erase: assert property (p_mismatch_no_erase) else $error("erase on mismatch");

  property p_needs_prepare;
    exec && opcode_q == OP_ERASE_UNIT && !prep_q |=> err_q[2] && !erase_unit_go;
  endproperty
  a_needs_prepare: assert property (p_needs_prepare) else $error("erase without prepare");

  property p_frozen_rejects;
    exec && frozen_q && (opcode_q == OP_SET_PW || opcode_q == OP_UNLOCK ||
                         opcode_q == OP_ERASE_UNIT || opcode_q == OP_DISABLE_PW)
      |=> err_q[2] && done_q && frozen_q;
  endproperty
  a_frozen_rejects: assert property (p_frozen_rejects) else $error("frozen accepted lock op");

  property p_frozen_sticks;
    frozen_q |=> frozen_q [*2];
  endproperty
  a_frozen_sticks: assert property (p_frozen_sticks) else $error("frozen cleared");

  property p_freeze_count;
    exec && opcode_q == OP_FREEZE && sec_supported |=> count_q == 8'h00 && frozen_q && !err_q[2];
  endproperty
  a_freeze_count: assert property (p_freeze_count) else $error("freeze count not zero");

  property p_wear_path;
    exec && opcode_q == OP_FREEZE && !sec_supported |=> wear_spread_cmd ##1 !wear_spread_cmd;
  endproperty
  a_wear_path: assert property (p_wear_path) else $error("wear spread missing");

  property p_tries_down;
    exec && opcode_q == OP_UNLOCK && locked_q && !frozen_q && sec_supported &&
      tries_q != 3'h0 && !pw_match_c |=> tries_q == $past(tries_q) - 3'h1;
  endproperty
  a_tries_down: assert property (p_tries_down) else $error("tries not decremented");

  property p_unlocked_tries;
    exec && opcode_q == OP_UNLOCK && !locked_q |=> $stable(tries_q);
  endproperty
  a_unlocked_tries: assert property (p_unlocked_tries) else $error("tries moved unlocked");

  // A full sector takes far longer than a delay range may span, so the end is
  // checked at the execute cycle instead of counted from the opcode write
  property p_busy_done;
    op_start |=> busy && !done_q;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("busy or done wrong");

  property p_exec_done;
    exec |=> !busy && done_q;
  endproperty
  a_exec_done: assert property (p_exec_done) else $error("no completion after execute");

endmodule

// [tb/scs_host.sv]
// Host model: AXI4-Lite master, one access at a time.
// Assumes one clock; ready sampled at the falling edge.
`timescale 1ns/10ps
module scs_host (
  input  wire logic        aclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  output logic             tmo
);
  logic [1:0] bresp_seen;  // Last write response, for the bench
  // Quiet bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tmo} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 8'h00, 32'h0, 4'hF};
  end
  // Write; released payload inverted so stale values never look valid
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic a, w, b, ta, tw, tb;
    int i;
    {a, w, b} = '0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {ad, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (i = 0; i < 64 && !b; i++) begin
      @(negedge aclk);
      {ta, tw, tb} = {!a && s_axi_awready, !w && s_axi_wready, s_axi_bvalid};
      if (tb) bresp_seen = s_axi_bresp;
      @(posedge aclk);
      if (ta) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~ad};
      if (tw) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      if (tb) s_axi_bready <= 1'b0;
      {a, w, b} = {a | ta, w | tw, tb};
    end
    tmo <= !b;
  endtask
  // Read; data and response taken with rvalid
  task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    logic a, t, ta;
    int i;
    {a, t} = '0;
    @(posedge aclk);
    s_axi_araddr <= ad;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (i = 0; i < 64 && !t; i++) begin
      @(negedge aclk);
      {ta, t, d, r} = {!a && s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ta) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~ad};
      if (t) s_axi_rready <= 1'b0;
      a = a | ta;
    end
    tmo <= !t;
  endtask
endmodule

// [tb/test_storage_card_security_commands.sv]
// Bench: security command sequences over the register bus.
// Assumes scs_host as bus master; pulses counted here.
`timescale 1ns/10ps
module test_storage_card_security_commands import scs_pkg::*;;
  localparam logic [15:0] A = 16'hA5A5, B = 16'h5A5A, X = 16'h1234;
  logic aclk = 0, aresetn = 0, nv_resetn = 0, sec_supported = 1;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic busy, erase_unit_go, wear_spread_cmd, tmo;
  int   fail_count = 0, n_compared = 0, n_go = 0, n_wear = 0;
  scs_core DUT (.aclk, .aresetn, .nv_resetn, .sec_supported, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy, .erase_unit_go,
    .wear_spread_cmd);
  scs_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tmo);
  always #20 aclk = ~aclk;
  // Pulse outputs last one cycle; count mid-cycle, clear of the launching edge
  always @(negedge aclk) begin
    n_go += (erase_unit_go === 1'b1);
    n_wear += (wear_spread_cmd === 1'b1);
  end
  always @(posedge tmo) begin
    fail_count++;
    final_report();
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input string nm, input logic [7:0] ad, input logic [31:0] m, e);
    host.rd(ad, rv, rr);
    chk(nm, e, rv & m);
    chk(nm, RESP_OKAY, rr);
  endtask
  task automatic rst();
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
  endtask
  // Opcode, whole sector where needed, bounded wait, error byte
  task automatic cmd(input logic [7:0] op, input logic [15:0] c, p, input logic [7:0] e);
    int i;
    host.wr(8'h1C, {24'h0, op});
    if (op inside {OP_SET_PW, OP_UNLOCK, OP_ERASE_UNIT, OP_DISABLE_PW}) begin
      rc("busy drq", 8'h24, 32'h3, 32'h3);
      for (i = 0; i < 256; i++) host.wr(8'h20, {16'h0, i == 0 ? c : (i < 17 ? p : 16'h0)});
    end
    for (i = 0; i < 50 && busy !== 1'b0; i++) @(negedge aclk);
    chk("busy", 0, busy);
    if (busy !== 1'b0) final_report();
    rc("error", 8'h04, 32'hFF, {24'h0, e});
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    nv_resetn <= 1;
    @(posedge aclk);
    aresetn <= 1;
    rc("status", 8'h24, 32'h7FF, 32'h500);
    host.rd(8'h30, rv, rr);
    chk("decode", RESP_DECERR, rr);
    host.wr(8'h30, 32'h0);
    chk("write decode", RESP_DECERR, host.bresp_seen);
    cmd(OP_SET_PW, 0, A, 8'h00);
    cmd(OP_SET_PW, 1, B, 8'h00);
    rc("arm", 8'h24, 32'hE0, 32'h40);
    rst();
    rc("lock", 8'h24, 32'h60, 32'h60);
    cmd(OP_UNLOCK, 1, B, 8'h00);
    rc("lock", 8'h24, 32'h20, 32'h0);
    rst();
    repeat (5) cmd(OP_UNLOCK, 0, X, 8'h04);
    rc("tries", 8'h24, 32'h700, 32'h0);
    cmd(OP_UNLOCK, 0, A, 8'h04);
    cmd(OP_ERASE_PREP, 0, 0, 8'h00);
    cmd(OP_ERASE_UNIT, 0, A, 8'h04);
    $display("test lockout ended");
    rst();
    cmd(OP_UNLOCK, 0, A, 8'h00);
    cmd(OP_UNLOCK, 0, X, 8'h04);
    rc("tries", 8'h24, 32'h720, 32'h500);
    cmd(OP_SET_PW, 16'h0100, A, 8'h00);
    rst();
    cmd(OP_UNLOCK, 1, B, 8'h04);
    cmd(OP_UNLOCK, 0, A, 8'h00);
    cmd(OP_ERASE_UNIT, 0, A, 8'h04);
    cmd(OP_ERASE_PREP, 0, 0, 8'h00);
    cmd(OP_ERASE_UNIT, 0, X, 8'h04);
    cmd(OP_ERASE_PREP, 0, 0, 8'h00);
    cmd(OP_ERASE_UNIT, 0, A, 8'h00);
    chk("erase", 1, n_go);
    $display("test unlock erase ended");
    cmd(OP_SET_PW, 0, A, 8'h00);
    host.wr(8'h08, 32'h33);
    chk("write resp", RESP_OKAY, host.bresp_seen);
    cmd(OP_FREEZE, 0, 0, 8'h00);
    rc("count", 8'h08, 32'hFF, 32'h0);
    cmd(OP_FREEZE, 0, 0, 8'h00);
    rc("frozen", 8'h24, 32'h10, 32'h10);
    cmd(OP_SET_PW, 0, A, 8'h04);
    cmd(OP_UNLOCK, 0, A, 8'h04);
    cmd(OP_DISABLE_PW, 0, A, 8'h04);
    cmd(OP_ERASE_PREP, 0, 0, 8'h00);
    cmd(OP_ERASE_UNIT, 0, A, 8'h04);
    rst();
    rc("frozen", 8'h24, 32'h10, 32'h0);
    host.wr(8'h18, 32'h40);
    host.wr(8'h14, 32'h01);
    cmd(8'h70, 0, 0, 8'h10);
    host.wr(8'h14, 32'h00);
    cmd(8'h7F, 0, 0, 8'h00);
    host.wr(8'h18, 32'h0F);
    cmd(8'h70, 0, 0, 8'h00);
    host.wr(8'h14, 32'h04);
    cmd(8'h71, 0, 0, 8'h10);
    sec_supported <= 0;
    cmd(OP_FREEZE, 0, 0, 8'h00);
    chk("wear", 1, n_wear);
    rc("frozen", 8'h24, 32'h10, 32'h0);
    $display("test freeze seek ended");
    final_report();
  end
endmodule
